// ==== src/pmc_pkg.sv ====
// Constants and types of the PLL loop and modulator configuration bank.
package pmc_pkg;

  // ----------------------------------------------------------------
  // Serial interface and register map
  // ----------------------------------------------------------------
  // Target address of the serial port; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h5a;
  localparam logic [7:0] OFS_MOD_CTRL = 8'h21;
  localparam logic [7:0] OFS_PLL_CTRL_FIRST = 8'h22;
  localparam logic [7:0] OFS_PLL_CTRL_SECOND = 8'h23;
  localparam logic [7:0] OFS_LF_R2 = 8'h24;
  localparam logic [7:0] OFS_LF_C1 = 8'h25;
  localparam int REG_COUNT = 5;
  localparam logic [7:0] REG_COUNT_B = 8'h05;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Reset values are the factory defaults; write and read masks per register.
  localparam logic [REG_COUNT-1:0][7:0] RST_VAL = {8'h00, 8'h28, 8'h03, 8'h28, 8'h0c};
  localparam logic [REG_COUNT-1:0][7:0] WR_MASK = {8'h07, 8'hff, 8'h74, 8'hef, 8'h0f};
  localparam logic [REG_COUNT-1:0][7:0] RD_MASK = {8'h07, 8'hff, 8'h77, 8'hef, 8'h0f};

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int DITHER_LSB = 2;
  localparam int ORDER_LSB = 0;
  localparam int DOUBLER_BIT = 5;
  localparam int CP_LSB = 0;
  localparam int DELAY_LSB = 4;
  localparam int C3_BIT = 2;
  localparam int C1_LSB = 0;
  localparam logic [1:0] DITHER_WEAK = 2'h0;
  localparam logic [1:0] DITHER_OFF = 2'h3;
  localparam logic [1:0] ORDER_INTEGER = 2'h0;
  localparam logic [1:0] ORDER_THIRD = 2'h3;
  localparam logic [3:0] CP_1P6_MA = 4'h4;
  localparam logic [3:0] CP_6P4_MA = 4'h8;
  localparam logic [2:0] DELAY_NONE = 3'h0;
  localparam logic [2:0] DELAY_FIRST_50MHZ = 3'h4;
  localparam logic [8:0] C1_BASE_PF = 9'h005;
  localparam logic [8:0] C1_STEP_PF = 9'h032;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEV_ACK = 4'h3,
    ST_PTR = 4'h2,
    ST_PTR_ACK = 4'h6,
    ST_WR = 4'h7,
    ST_WR_ACK = 4'h5,
    ST_RD = 4'h4,
    ST_RD_ACK = 4'hc
  } pmc_fsm_t;

  typedef struct packed {
    logic dither_enable;
    logic dither_reserved;
    logic integer_mode;
    logic third_order;
    logic order_reserved;
    logic doubler_enable;
    logic [3:0] charge_pump_current_select;
    logic charge_pump_current_reserved;
    logic [2:0] charge_pump_delay_select;
    logic delay_for_50mhz;
    logic third_capacitor_enable;
    logic [7:0] loop_resistor_two_code;
    logic [8:0] c1_picofarads;
    logic [21:0] modulator_numerator;
  } pmc_pll_cfg_t;

  typedef struct packed {
    pmc_fsm_t fsm;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_out;
    logic [REG_COUNT-1:0][7:0] regs;
    pmc_pll_cfg_t cfg;
  } pmc_state_t;

endpackage

// ==== src/pmc_sync.sv ====
// Two-flop synchroniser for the serial port pins.
`timescale 1ns/10ps
module pmc_sync #(
  parameter int W = 2
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // The idle serial bus is high, so both stages reset high.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '1;
      sync_out <= '1;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pmc_sync

// ==== src/pmc_decode.sv ====
// Decoder from stored register bytes to PLL control fields.
`timescale 1ns/10ps
module pmc_decode (
  input wire logic [pmc_pkg::REG_COUNT-1:0][7:0] regs,
  input wire logic [21:0] frac_numerator,
  output pmc_pkg::pmc_pll_cfg_t cfg
);

  logic [1:0] dither;
  logic [1:0] order;
  logic [2:0] c1_code;

  always_comb begin
    dither = regs[0][pmc_pkg::DITHER_LSB +: 2];
    order = regs[0][pmc_pkg::ORDER_LSB +: 2];
    c1_code = regs[4][pmc_pkg::C1_LSB +: 3];
    cfg.dither_enable = (dither == pmc_pkg::DITHER_WEAK);
    cfg.dither_reserved = (dither != pmc_pkg::DITHER_WEAK) && (dither != pmc_pkg::DITHER_OFF);
    cfg.integer_mode = (order == pmc_pkg::ORDER_INTEGER);
    cfg.third_order = (order == pmc_pkg::ORDER_THIRD);
    cfg.order_reserved = !cfg.integer_mode && !cfg.third_order;
    cfg.doubler_enable = regs[1][pmc_pkg::DOUBLER_BIT];
    cfg.charge_pump_current_select = regs[1][pmc_pkg::CP_LSB +: 4];
    cfg.charge_pump_current_reserved = (cfg.charge_pump_current_select != pmc_pkg::CP_1P6_MA) &&
                                       (cfg.charge_pump_current_select != pmc_pkg::CP_6P4_MA);
    cfg.charge_pump_delay_select = regs[2][pmc_pkg::DELAY_LSB +: 3];
    cfg.delay_for_50mhz = (cfg.charge_pump_delay_select >= pmc_pkg::DELAY_FIRST_50MHZ);
    cfg.third_capacitor_enable = regs[2][pmc_pkg::C3_BIT];
    cfg.loop_resistor_two_code = regs[3];
    cfg.c1_picofarads = pmc_pkg::C1_BASE_PF + pmc_pkg::C1_STEP_PF * {6'h00, c1_code};
    // Integer mode ignores the fraction, so the modulator sees zero.
    cfg.modulator_numerator = cfg.integer_mode ? 22'h000000 : frac_numerator;
  end

endmodule // pmc_decode

// ==== src/pmc_top.sv ====
// Serial-port register bank for PLL loop filter and modulator settings.
`timescale 1ns/10ps
module pmc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic [21:0] frac_numerator,
  output pmc_pkg::pmc_pll_cfg_t pll_cfg
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;

  pmc_sync #(
    .W(2)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({scl_pin, sda_pin_in}),
    .sync_out(pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // ----------------------------------------------------------------
  // State and field decode
  // ----------------------------------------------------------------
  pmc_pkg::pmc_state_t st_r;
  pmc_pkg::pmc_state_t st_nxt;
  pmc_pkg::pmc_pll_cfg_t cfg_dec;

  pmc_decode u_decode (
    .regs(st_r.regs),
    .frac_numerator(frac_numerator),
    .cfg(cfg_dec)
  );

  // ----------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------
  function automatic logic ptr_hit(input logic [7:0] p);
    logic [7:0] idx;
    idx = p - pmc_pkg::OFS_MOD_CTRL;
    return (p >= pmc_pkg::OFS_MOD_CTRL) && (idx < pmc_pkg::REG_COUNT_B);
  endfunction

  // Unmapped offsets and reserved bits read as zero, except the
  // fixed pair in the second control register which reads three.
  function automatic logic [7:0] rd_byte(input logic [7:0] p,
                                         input logic [pmc_pkg::REG_COUNT-1:0][7:0] r);
    logic [7:0] idx;
    logic [7:0] val;
    idx = p - pmc_pkg::OFS_MOD_CTRL;
    val = 8'h00;
    for (int i = 0; i < pmc_pkg::REG_COUNT; i++) begin
      if (ptr_hit(p) && idx == 8'(i)) begin
        val = r[i] & pmc_pkg::RD_MASK[i];
      end
    end
    return val;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rd_now;
  logic [7:0] wr_idx;

  always_comb begin
    scl_rise = scl_s && !st_r.scl_q;
    scl_fall = !scl_s && st_r.scl_q;
    start_cond = scl_s && st_r.scl_q && st_r.sda_q && !sda_s;
    stop_cond = scl_s && st_r.scl_q && !st_r.sda_q && sda_s;
    rd_now = rd_byte(st_r.ptr, st_r.regs);
    wr_idx = st_r.ptr - pmc_pkg::OFS_MOD_CTRL;
  end

  // ----------------------------------------------------------------
  // Serial protocol engine
  // ----------------------------------------------------------------
  // The target drives SDA only low; the enable is the whole story and
  // the data bit stays zero. Changes happen on SCL falling edges so that
  // SDA is stable while SCL is high.
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_q = scl_s;
    st_nxt.sda_q = sda_s;
    st_nxt.sda_out = 1'b0;
    st_nxt.cfg = cfg_dec;
    if (start_cond) begin
      st_nxt.fsm = pmc_pkg::ST_DEV;
      st_nxt.bitcnt = 4'h0;
      st_nxt.sda_oe = 1'b0;
    end else if (stop_cond) begin
      st_nxt.fsm = pmc_pkg::ST_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else begin
      unique case (st_r.fsm)
        pmc_pkg::ST_IDLE: begin
          st_nxt.sda_oe = 1'b0;
        end
        pmc_pkg::ST_DEV, pmc_pkg::ST_PTR, pmc_pkg::ST_WR: begin
          if (scl_rise) begin
            st_nxt.shift = {st_r.shift[6:0], sda_s};
            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
          end else if (scl_fall && st_r.bitcnt == pmc_pkg::BITS_PER_BYTE) begin
            st_nxt.bitcnt = 4'h0;
            st_nxt.sda_oe = 1'b1;
            if (st_r.fsm == pmc_pkg::ST_DEV) begin
              if (st_r.shift[7:1] == pmc_pkg::DEV_ADDR) begin
                st_nxt.rw = st_r.shift[0];
                st_nxt.fsm = pmc_pkg::ST_DEV_ACK;
              end else begin
                // Another target is addressed; stay off the bus.
                st_nxt.sda_oe = 1'b0;
                st_nxt.fsm = pmc_pkg::ST_IDLE;
              end
            end else if (st_r.fsm == pmc_pkg::ST_PTR) begin
              st_nxt.ptr = st_r.shift;
              st_nxt.fsm = pmc_pkg::ST_PTR_ACK;
            end else begin
              for (int i = 0; i < pmc_pkg::REG_COUNT; i++) begin
                if (ptr_hit(st_r.ptr) && wr_idx == 8'(i)) begin
                  st_nxt.regs[i] = (st_r.regs[i] & ~pmc_pkg::WR_MASK[i]) |
                                   (st_r.shift & pmc_pkg::WR_MASK[i]);
                end
              end
              st_nxt.ptr = st_r.ptr + 8'h01;
              st_nxt.fsm = pmc_pkg::ST_WR_ACK;
            end
          end
        end
        pmc_pkg::ST_DEV_ACK: begin
          if (scl_fall) begin
            if (st_r.rw) begin
              st_nxt.shift = rd_now;
              st_nxt.sda_oe = !rd_now[7];
              st_nxt.bitcnt = 4'h1;
              st_nxt.fsm = pmc_pkg::ST_RD;
            end else begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.fsm = pmc_pkg::ST_PTR;
            end
          end
        end
        pmc_pkg::ST_PTR_ACK, pmc_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.bitcnt = 4'h0;
            st_nxt.fsm = pmc_pkg::ST_WR;
          end
        end
        pmc_pkg::ST_RD: begin
          if (scl_fall) begin
            if (st_r.bitcnt == pmc_pkg::BITS_PER_BYTE) begin
              st_nxt.sda_oe = 1'b0;
              st_nxt.ptr = st_r.ptr + 8'h01;
              st_nxt.fsm = pmc_pkg::ST_RD_ACK;
            end else begin
              st_nxt.shift = {st_r.shift[6:0], 1'b0};
              st_nxt.sda_oe = !st_r.shift[6];
              st_nxt.bitcnt = st_r.bitcnt + 4'h1;
            end
          end
        end
        pmc_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            st_nxt.nack = sda_s;
          end else if (scl_fall) begin
            if (st_r.nack) begin
              // Controller ended the read; wait for stop or restart.
              st_nxt.fsm = pmc_pkg::ST_IDLE;
            end else begin
              st_nxt.shift = rd_now;
              st_nxt.sda_oe = !rd_now[7];
              st_nxt.bitcnt = 4'h1;
              st_nxt.fsm = pmc_pkg::ST_RD;
            end
          end
        end
        default: begin
          st_nxt.fsm = pmc_pkg::ST_IDLE;
          st_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset loads the stored defaults; the decoded fields follow one
  // cycle later, so the reset image of cfg is the decode of the defaults.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.fsm <= pmc_pkg::ST_IDLE;
      st_r.scl_q <= 1'b1;
      st_r.sda_q <= 1'b1;
      st_r.shift <= 8'h00;
      st_r.bitcnt <= 4'h0;
      st_r.rw <= 1'b0;
      st_r.nack <= 1'b0;
      st_r.ptr <= 8'h00;
      st_r.sda_oe <= 1'b0;
      st_r.sda_out <= 1'b0;
      st_r.regs <= pmc_pkg::RST_VAL;
      st_r.cfg.dither_enable <= 1'b0;
      st_r.cfg.dither_reserved <= 1'b0;
      st_r.cfg.integer_mode <= 1'b1;
      st_r.cfg.third_order <= 1'b0;
      st_r.cfg.order_reserved <= 1'b0;
      st_r.cfg.doubler_enable <= 1'b1;
      st_r.cfg.charge_pump_current_select <= pmc_pkg::CP_6P4_MA;
      st_r.cfg.charge_pump_current_reserved <= 1'b0;
      st_r.cfg.charge_pump_delay_select <= pmc_pkg::DELAY_NONE;
      st_r.cfg.delay_for_50mhz <= 1'b0;
      st_r.cfg.third_capacitor_enable <= 1'b0;
      st_r.cfg.loop_resistor_two_code <= pmc_pkg::RST_VAL[3];
      st_r.cfg.c1_picofarads <= pmc_pkg::C1_BASE_PF;
      st_r.cfg.modulator_numerator <= 22'h000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sda_pin_out = st_r.sda_out;
  assign sda_pin_oe = st_r.sda_oe;
  assign pll_cfg = st_r.cfg;

endmodule // pmc_top

// ==== verification/pmc_asserts.sv ====
// Port checks for the PLL configuration bank.
`timescale 1ns/10ps
module pmc_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  input wire logic sda_pin_out,
  input wire logic sda_pin_oe,
  input wire logic [21:0] frac_numerator,
  input wire pmc_pkg::pmc_pll_cfg_t pll_cfg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----------------
  // Decode relations
  // ----------------
  a_dither_codes: assert property (
    $onehot0({pll_cfg.dither_enable, pll_cfg.dither_reserved}))
    else $error("dither flags clash");
  a_order_codes: assert property (
    $onehot({pll_cfg.integer_mode, pll_cfg.third_order, pll_cfg.order_reserved}))
    else $error("order flags clash");
  a_pump_codes: assert property (
    pll_cfg.charge_pump_current_reserved != (pll_cfg.charge_pump_current_select inside {4'h4, 4'h8}))
    else $error("pump reserved flag wrong");
  a_delay_band: assert property (
    pll_cfg.delay_for_50mhz == pll_cfg.charge_pump_delay_select[2])
    else $error("delay band flag wrong");
  a_c1_steps: assert property (
    pll_cfg.c1_picofarads inside {9'h005, 9'h037, 9'h069, 9'h09b, 9'h0cd, 9'h0ff, 9'h131, 9'h163})
    else $error("c1 value off its steps");
  a_num_integer: assert property (
    pll_cfg.integer_mode |-> pll_cfg.modulator_numerator == 22'h000000)
    else $error("numerator not cleared in integer mode");
  a_num_follow: assert property (
    !pll_cfg.integer_mode |-> pll_cfg.modulator_numerator == $past(frac_numerator))
    else $error("numerator does not follow input");
  // -----------
  // Serial pins
  // -----------
  // The data line only ever pulls low, so a high drive value would fight the pull-up.
  a_pin_low: assert property (
    sda_pin_oe |-> sda_pin_out == 1'b0)
    else $error("data pin driven high");
  a_oe_timing: assert property (
    $changed(sda_pin_oe) |-> !$past(scl_pin, 2))
    else $error("data drive changed while clock high");
  a_oe_hold: assert property (
    $rose(sda_pin_oe) |-> sda_pin_oe [*8])
    else $error("data drive shorter than a bit");
  c_third: cover property (pll_cfg.third_order && pll_cfg.third_capacitor_enable);
  c_slow_delay: cover property (pll_cfg.delay_for_50mhz);
  c_ack: cover property ($rose(sda_pin_oe));
endmodule // pmc_asserts

bind pmc_top pmc_asserts u_asserts (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .scl_pin(scl_pin),
  .sda_pin_in(sda_pin_in),
  .sda_pin_out(sda_pin_out),
  .sda_pin_oe(sda_pin_oe),
  .frac_numerator(frac_numerator),
  .pll_cfg(pll_cfg)
);

// ==== verification/pmc_top_tb.sv ====
// Self-checking bench for the PLL configuration bank.
`timescale 1ns/10ps
module pmc_top_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl = 1'b1;
  logic sda_drv = 1'b1;
  logic sda_w;
  logic sda_pin_out;
  logic sda_pin_oe;
  logic [21:0] frac = 22'h000000;
  pmc_pkg::pmc_pll_cfg_t cfg;
  logic [31:0] x = 32'h00000058;
  logic [7:0] bufd [5];
  logic [7:0] mr [5];
  logic [7:0] rv [5] = '{8'h0c, 8'h28, 8'h03, 8'h28, 8'h00};
  logic [7:0] wm [5] = '{8'h0f, 8'hef, 8'h74, 8'hff, 8'h07};
  logic [7:0] rm [5] = '{8'h0f, 8'hef, 8'h77, 8'hff, 8'h07};
  logic [7:0] dw = {pmc_pkg::DEV_ADDR, 1'b0};
  logic [63:0] exp_q [$];
  logic [63:0] got_v;
  string got_n;
  event got_ev;
  int miscompares = 0;
  int tests_run = 0;
  // The line is pulled up, so it reads low whenever either party enables its driver.
  assign sda_w = sda_drv & ~(sda_pin_oe & ~sda_pin_out);
  pmc_top dut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .scl_pin(scl),
    .sda_pin_in(sda_w),
    .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe),
    .frac_numerator(frac),
    .pll_cfg(cfg)
  );
  initial forever #2.5 sys_clk = ~sys_clk;
  // -------------
  // Bus primitives
  // -------------
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Each phase lasts several clocks so the two-flop synchroniser never merges edges.
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_drv = b;
    tick(5);
    scl = 1'b1;
    tick(3);
    r = sda_w;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic am, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(am, k);
  endtask
  task automatic start();
    tick(2);
    sda_drv = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(6);
    sda_drv = 1'b0;
    tick(6);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_drv = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(6);
    sda_drv = 1'b1;
    tick(6);
  endtask
  task automatic chk(string n, logic [63:0] e, logic [63:0] v);
    exp_q.push_back(e);
    got_n = n;
    got_v = v;
    -> got_ev;
    tick(1);
  endtask
  task automatic send(logic [7:0] d, logic ea);
    logic [7:0] q;
    logic k;
    byte_io(d, 1'b1, q, k);
    chk("ack", {63'h0, ea}, {63'h0, k});
  endtask
  task automatic wr(logic [7:0] d, logic [7:0] p, int n, logic ea);
    logic [7:0] a;
    int i;
    start();
    send(d, ea);
    send(p, ea);
    for (int j = 0; j < n; j++) begin
      a = p + j[7:0];
      i = a - 8'h21;
      send(bufd[j], ea);
      if (!ea && a inside {[8'h21:8'h25]}) mr[i] = (mr[i] & ~wm[i]) | (bufd[j] & wm[i]);
    end
    stop();
  endtask
  task automatic rd(logic [7:0] p, int n);
    logic [7:0] q;
    logic [7:0] a;
    logic k;
    start();
    send(dw, 1'b0);
    send(p, 1'b0);
    start();
    send(dw | 8'h01, 1'b0);
    for (int j = 0; j < n; j++) begin
      a = p + j[7:0];
      byte_io(8'hff, j == n - 1, q, k);
      chk("read", {56'h0, (a inside {[8'h21:8'h25]}) ? mr[a - 8'h21] & rm[a - 8'h21] : 8'h00}, {56'h0, q});
    end
    stop();
  endtask
  function automatic pmc_pkg::pmc_pll_cfg_t model_cfg();
    pmc_pkg::pmc_pll_cfg_t e;
    e.dither_enable = mr[0][3:2] == 2'h0;
    e.dither_reserved = ^mr[0][3:2];
    e.integer_mode = mr[0][1:0] == 2'h0;
    e.third_order = mr[0][1:0] == 2'h3;
    e.order_reserved = ^mr[0][1:0];
    e.doubler_enable = mr[1][5];
    e.charge_pump_current_select = mr[1][3:0];
    e.charge_pump_current_reserved = !(mr[1][3:0] inside {4'h4, 4'h8});
    e.charge_pump_delay_select = mr[2][6:4];
    e.delay_for_50mhz = mr[2][6];
    e.third_capacitor_enable = mr[2][2];
    e.loop_resistor_two_code = mr[3];
    e.c1_picofarads = 9'h005 + 9'h032 * {6'h00, mr[4][2:0]};
    e.modulator_numerator = e.integer_mode ? 22'h000000 : frac;
    return e;
  endfunction
  task automatic cfg_chk();
    tick(8);
    chk("pll_cfg", {9'h0, model_cfg()}, {9'h0, cfg});
  endtask
  // ---------------
  // Checks and runs
  // ---------------
  initial begin : monitor
    logic [63:0] e;
    forever begin
      @(got_ev);
      e = exp_q.pop_front();
      tests_run++;
      if (e !== got_v) begin
        miscompares++;
        $display("unexpected %s expected %h seen %h", got_n, e, got_v);
      end
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    logic [31:0] r;
    mr = rv;
    tick(6);
    sys_rst = 1'b0;
    tick(3);
    cfg_chk();
    rd(8'h21, 6);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      frac = r[21:0];
      bufd[0] = {r[7:4], k[1:0], k[1:0]};
      bufd[1] = {r[9:8], k[0], r[10], k[1] ? 4'h8 : (k[0] ? 4'h4 : r[14:11])};
      bufd[2] = {r[15], k[2:0], r[16], k[0], 2'h3};
      bufd[3] = r[24:17];
      bufd[4] = {r[29:25], k[2:0]};
      wr(dw, 8'h21, 5, 1'b0);
      cfg_chk();
      rd(8'h21, 5);
    end
    wr(dw ^ 8'h02, 8'h21, 2, 1'b1);
    wr(dw, 8'hfe, 4, 1'b0);
    cfg_chk();
    bufd[0] = 8'h03;
    wr(dw, 8'h23, 1, 1'b0);
    cfg_chk();
    sys_rst = 1'b1;
    tick(6);
    sys_rst = 1'b0;
    mr = rv;
    tick(3);
    cfg_chk();
    rd(8'h24, 3);
    report_and_stop();
  end
endmodule // pmc_top_tb
